// ### rtl/csf_cfg.svh
// register map, field positions and reset values of the sfr bank
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH
// data memory addresses (low 7 address bits are decoded)
`define CSF_A_WIN    7'h00
`define CSF_A_PTR    7'h01
`define CSF_A_WORK   7'h05
`define CSF_A_PC_LO  7'h06
`define CSF_A_TBLP   7'h07
`define CSF_A_TBL_HI 7'h08
`define CSF_A_STAT   7'h0a
`define CSF_A_IRQC   7'h0b
`define CSF_A_TCNT   7'h0d
`define CSF_A_TSET   7'h0e
`define CSF_A_DIRA   7'h13
`define CSF_A_DIRB   7'h15
`define CSF_A_DIRC   7'h17
`define CSF_A_DIRD   7'h19
`define CSF_A_DUTY0  7'h1a
`define CSF_A_DUTY1  7'h1b
`define CSF_RAM_BASE 7'h40
// status flag positions
`define CSF_ST_C     0
`define CSF_ST_NIB   1
`define CSF_ST_Z     2
`define CSF_ST_WRAP  3
// irq control positions
`define CSF_IC_GATE  0
`define CSF_IC_EXT   1
`define CSF_IC_TIMER 2
// reset values
`define CSF_ZERO     8'h00
`define CSF_DIR_RST  8'hff
`endif

// ### rtl/csf_pkg.sv
// types shared by the sfr bank and its users
package csf_pkg;
   typedef enum logic [3:0] {
      OP_NOP   = 4'b0000,
      OP_LOAD  = 4'b0001,
      OP_STORE = 4'b0010,
      OP_LOADI = 4'b0011,
      OP_ADD   = 4'b0100,
      OP_SUB   = 4'b0101,
      OP_AND   = 4'b0110,
      OP_OR    = 4'b0111,
      OP_XOR   = 4'b1000,
      OP_RLC   = 4'b1001,
      OP_RRC   = 4'b1010,
      OP_TABRD = 4'b1011,
      OP_HALT  = 4'b1100,
      OP_KICK  = 4'b1101,
      OP_IRQ_RET = 4'b1110
   } csf_op_t;
   typedef struct packed {
      csf_op_t    op;
      logic [7:0] addr;
      logic [7:0] imm;
      logic       to_mem;
   } csf_instr_t;
   typedef struct packed {
      logic [7:0] pa;
      logic [7:0] pb;
      logic [7:0] pc;
      logic [7:0] pd;
   } csf_dir_t;
   typedef struct packed {
      logic [7:0] ch1;
      logic [7:0] ch0;
   } csf_duty_t;
endpackage : csf_pkg

// ### rtl/csf_regs.sv
// special function register bank with accumulator datapath
`timescale 1ns/1ps
`include "csf_cfg.svh"

module csf_regs (
   // clock and reset
   input  wire logic             CLK,
   input  wire logic             NRST,
   input  wire logic             CE,
   // instruction issue
   input  wire logic             INSTR_VALID,
   input  wire csf_pkg::csf_instr_t INSTR,
   input  wire logic [15:0]      TBL_WORD,
   input  wire logic [7:0]       PC_NOW,
   // core events
   input  wire logic             IRQ_ENTRY,
   input  wire logic             WDT_TIMEOUT,
   input  wire logic             TIMER_INC,
   // program counter control
   output logic                  PC_JUMP,
   output logic [7:0]            PC_TARGET,
   output logic                  DUMMY_CYCLE,
   // register views
   output logic [7:0]            WORK_REG,
   output logic [7:0]            STATUS_FLAGS,
   output logic [7:0]            TBL_PTR,
   output logic [7:0]            TIMER_COUNT,
   output logic [7:0]            TIMER_SETUP,
   output logic                  EXT_IRQ_EN,
   output logic                  TIMER_IRQ_EN,
   output csf_pkg::csf_dir_t     PORT_DIR,
   output csf_pkg::csf_duty_t    PWM_DUTY
);
   import csf_pkg::*;

   // ==========================================================
   // storage
   logic [6:0] ptr;               // top bit not stored
   logic [7:0] work;
   logic [7:0] tblp;
   logic [7:0] lookup_hi;
   logic [7:0] tset;
   logic [7:0] tcnt;
   logic [3:0] arith;             // {wrap, zero, nibble, carry}
   logic       halt_flag;
   logic       wdto;
   logic [2:0] irqc;
   logic       jump;
   logic [7:0] pc_tgt;
   logic       dummy;
   csf_dir_t   dir;
   csf_duty_t  duty;
   logic [7:0] ram [0:63];

   // ==========================================================
   // decode
   logic       go;
   csf_op_t    op;
   logic [6:0] ea;
   logic       ea_null;
   logic [7:0] opnd;
   logic [7:0] res;
   logic [3:0] next_arith;
   logic [3:0] flag_upd;
   logic       wr_en;
   logic [7:0] wr_data;
   logic       work_we;

   assign go = INSTR_VALID && CE;
   assign op = INSTR.op;

   // effective address
   always_comb
   begin
      ea = INSTR.addr[6:0];
      ea_null = 1'b0;
      if (INSTR.addr[6:0] == `CSF_A_WIN)
      begin
         ea = ptr;
         ea_null = (ptr == `CSF_A_WIN);
      end
   end

   // operand read mux
   always_comb
   begin
      opnd = `CSF_ZERO;
      if (ea_null)
         opnd = `CSF_ZERO;
      else if (ea >= `CSF_RAM_BASE)
         opnd = ram[ea[5:0]];
      else if (ea == `CSF_A_PTR)
         opnd = {1'b1, ptr};
      else if (ea == `CSF_A_WORK)
         opnd = work;
      else if (ea == `CSF_A_PC_LO)
         opnd = PC_NOW;
      else if (ea == `CSF_A_TBLP)
         opnd = tblp;
      else if (ea == `CSF_A_TBL_HI)
         opnd = lookup_hi;
      else if (ea == `CSF_A_STAT)
         opnd = {2'b00, wdto, halt_flag, arith};
      else if (ea == `CSF_A_IRQC)
         opnd = {5'b00000, irqc};
      else if (ea == `CSF_A_TCNT)
         opnd = tcnt;
      else if (ea == `CSF_A_TSET)
         opnd = tset;
      else if (ea == `CSF_A_DIRA)
         opnd = dir.pa;
      else if (ea == `CSF_A_DIRB)
         opnd = dir.pb;
      else if (ea == `CSF_A_DIRC)
         opnd = dir.pc;
      else if (ea == `CSF_A_DIRD)
         opnd = dir.pd;
      else if (ea == `CSF_A_DUTY0)
         opnd = duty.ch0;
      else if (ea == `CSF_A_DUTY1)
         opnd = duty.ch1;
   end

   // alu and flag results
   always_comb
   begin
      logic [7:0] b;
      logic       cin;
      logic [8:0] s9;
      logic [4:0] s4;
      logic [7:0] s7;
      b = (op == OP_SUB) ? ~opnd : opnd;
      cin = (op == OP_SUB);
      s9 = {1'b0, work} + {1'b0, b} + {8'h00, cin};
      s4 = {1'b0, work[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      s7 = {1'b0, work[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
      res = opnd;
      next_arith = arith;
      flag_upd = 4'h0;
      case (op)
         OP_LOADI: res = INSTR.imm;
         OP_ADD, OP_SUB:
         begin
            res = s9[7:0];
            next_arith[`CSF_ST_C] = s9[8];
            next_arith[`CSF_ST_NIB] = s4[4];
            next_arith[`CSF_ST_Z] = (s9[7:0] == `CSF_ZERO);
            next_arith[`CSF_ST_WRAP] = s7[7] ^ s9[8];
            flag_upd = 4'hf;
         end
         OP_AND, OP_OR, OP_XOR:
         begin
            res = (op == OP_AND) ? (work & opnd) :
                  (op == OP_OR)  ? (work | opnd) : (work ^ opnd);
            next_arith[`CSF_ST_Z] = (res == `CSF_ZERO);
            flag_upd[`CSF_ST_Z] = 1'b1;
         end
         OP_RLC:
         begin
            res = {opnd[6:0], arith[`CSF_ST_C]};
            next_arith[`CSF_ST_C] = opnd[7];
            flag_upd[`CSF_ST_C] = 1'b1;
         end
         OP_RRC:
         begin
            res = {arith[`CSF_ST_C], opnd[7:1]};
            next_arith[`CSF_ST_C] = opnd[0];
            flag_upd[`CSF_ST_C] = 1'b1;
         end
         default: res = opnd;
      endcase
   end

   always_comb
   begin
      work_we = 1'b0;
      wr_en = 1'b0;
      wr_data = res;
      case (op)
         OP_LOAD, OP_LOADI: work_we = go;
         OP_STORE:
         begin
            wr_en = go;
            wr_data = work;
         end
         OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC:
         begin
            wr_en = go && INSTR.to_mem;
            work_we = go && !INSTR.to_mem;
         end
         OP_TABRD:
         begin
            wr_en = go;
            wr_data = TBL_WORD[7:0];
         end
         default: wr_en = 1'b0;
      endcase
      if (ea_null)
         wr_en = 1'b0;
   end

   // ==========================================================
   // registers
   // general purpose ram
   always_ff @(posedge CLK)
   begin
      if (wr_en && ea >= `CSF_RAM_BASE)
         ram[ea[5:0]] <= wr_data;
   end

   // pointer and table pointer
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ptr <= 7'h00;
         tblp <= `CSF_ZERO;
      end
      else if (wr_en && ea == `CSF_A_PTR)
         ptr <= wr_data[6:0];
      else if (wr_en && ea == `CSF_A_TBLP)
         tblp <= wr_data;
   end

   // work register
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         work <= `CSF_ZERO;
      else if (work_we)
         work <= res;
      else if (wr_en && ea == `CSF_A_WORK)
         work <= wr_data;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         jump <= 1'b0;
         pc_tgt <= `CSF_ZERO;
         dummy <= 1'b0;
      end
      else if (CE)
      begin
         jump <= wr_en && ea == `CSF_A_PC_LO;
         if (wr_en && ea == `CSF_A_PC_LO)
            pc_tgt <= wr_data;
         dummy <= jump;
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         lookup_hi <= `CSF_ZERO;
      else if (go && op == OP_TABRD)
         lookup_hi <= TBL_WORD[15:8];
   end

   // arithmetic flags
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         arith <= 4'h0;
      else if (wr_en && ea == `CSF_A_STAT)
         arith <= wr_data[3:0];
      else if (go)
         arith <= (arith & ~flag_upd) | (next_arith & flag_upd);
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         halt_flag <= 1'b0;
      else if (go && op == OP_HALT)
         halt_flag <= 1'b1;
      else if (go && op == OP_KICK)
         halt_flag <= 1'b0;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         wdto <= 1'b0;
      else if (CE && WDT_TIMEOUT)
         wdto <= 1'b1;
      else if (go && (op == OP_HALT || op == OP_KICK))
         wdto <= 1'b0;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         irqc <= 3'b000;
      else if (CE)
      begin
         if (wr_en && ea == `CSF_A_IRQC)
            irqc <= wr_data[2:0];
         if (IRQ_ENTRY)
            irqc[`CSF_IC_GATE] <= 1'b0;
         else if (go && op == OP_IRQ_RET)
            irqc[`CSF_IC_GATE] <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         tcnt <= `CSF_ZERO;
         tset <= `CSF_ZERO;
      end
      else if (CE)
      begin
         if (wr_en && ea == `CSF_A_TCNT)
            tcnt <= wr_data;
         else if (TIMER_INC)
            tcnt <= tcnt + 8'h01;
         if (wr_en && ea == `CSF_A_TSET)
            tset <= wr_data;
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         dir <= {4{`CSF_DIR_RST}};
         duty <= {2{`CSF_ZERO}};
      end
      else if (wr_en)
      begin
         if (ea == `CSF_A_DIRA)
            dir.pa <= wr_data;
         else if (ea == `CSF_A_DIRB)
            dir.pb <= wr_data;
         else if (ea == `CSF_A_DIRC)
            dir.pc <= wr_data;
         else if (ea == `CSF_A_DIRD)
            dir.pd <= wr_data;
         else if (ea == `CSF_A_DUTY0)
            duty.ch0 <= wr_data;
         else if (ea == `CSF_A_DUTY1)
            duty.ch1 <= wr_data;
      end
   end

   // outputs
   assign PC_JUMP = jump;
   assign PC_TARGET = pc_tgt;
   assign DUMMY_CYCLE = dummy;
   assign WORK_REG = work;
   assign STATUS_FLAGS = {2'b00, wdto, halt_flag, arith};
   assign TBL_PTR = tblp;
   assign TIMER_COUNT = tcnt;
   assign TIMER_SETUP = tset;
   assign EXT_IRQ_EN = irqc[`CSF_IC_GATE] & irqc[`CSF_IC_EXT];
   assign TIMER_IRQ_EN = irqc[`CSF_IC_GATE] & irqc[`CSF_IC_TIMER];
   assign PORT_DIR = dir;
   assign PWM_DUTY = duty;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   ptr_top_one_a: assert property ((go && op == OP_LOAD && INSTR.addr[6:0] == `CSF_A_PTR)
      |=> WORK_REG[7]) else $error("pointer top bit read low");
   pcl_jump_a: assert property ((wr_en && ea == `CSF_A_PC_LO)
      |=> PC_JUMP && PC_TARGET == $past(wr_data)) else $error("no jump");
   // a back-to-back low byte write legally keeps the jump pulse up
   dummy_follow_a: assert property ((PC_JUMP && CE && !(wr_en && ea == `CSF_A_PC_LO))
      |=> DUMMY_CYCLE && !PC_JUMP)
      else $error("dummy cycle missing");
   stat_protect_a: assert property ((wr_en && ea == `CSF_A_STAT && !WDT_TIMEOUT)
      |=> $stable(STATUS_FLAGS[5:4])) else $error("status write hit system flags");
   expiry_set_a: assert property ((CE && WDT_TIMEOUT) |=> STATUS_FLAGS[5])
      else $error("expiry flag not set");
   halt_flag_a: assert property ((go && op == OP_HALT && !WDT_TIMEOUT)
      |=> STATUS_FLAGS[4] && !STATUS_FLAGS[5]) else $error("halt flags wrong");
   add_carry_a: assert property ((go && op == OP_ADD && !INSTR.to_mem)
      |=> STATUS_FLAGS[0] == ($past(work) + $past(opnd) > 255))
      else $error("add carry wrong");
   zero_flag_a: assert property ((go && op == OP_XOR && !INSTR.to_mem)
      |=> STATUS_FLAGS[2] == (WORK_REG == 8'h00)) else $error("zero flag wrong");
   gate_entry_a: assert property ((CE && IRQ_ENTRY) |=> !EXT_IRQ_EN && !TIMER_IRQ_EN)
      else $error("gate open after entry");
   self_window_a: assert property ((go && op == OP_LOAD && ea_null)
      |=> WORK_REG == 8'h00) else $error("self window read nonzero");

   jump_seen_c: cover property (PC_JUMP ##1 DUMMY_CYCLE);
   irq_return_c: cover property ((CE && IRQ_ENTRY) ##[1:20] (go && op == OP_IRQ_RET));
   tabrd_seen_c: cover property (go && op == OP_TABRD && INSTR.addr[6:0] == `CSF_A_WIN);
endmodule : csf_regs

// ### sim/tb_csf_regs.sv
// self-checking bench for the sfr bank, driven through its instruction port
`timescale 1ns/1ps
`include "csf_cfg.svh"

module tb_csf_regs;
   import csf_pkg::*;

   // =====================================================================
   // bench signals
   typedef struct packed {
      csf_op_t    op;
      logic [7:0] pre;
      logic [7:0] w;
      logic [7:0] m;
      logic [7:0] res;
      logic [7:0] st;
   } csf_alu_t;

   logic               clk, nrst, ce, vld, irq, wdt, tinc, jmp, dmy, ext_en, timer_en;
   logic               mid;
   csf_instr_t         instr;
   logic [15:0]        tbl;
   logic [7:0]         pcn, tgt, work, stat, tptr, tcnt, tset;
   csf_dir_t           dir;
   csf_duty_t          duty;
   int                 errors, check_count, cyc;
   logic [6:0]         regs [9] = '{7'h13, 7'h15, 7'h17, 7'h19, 7'h1a, 7'h1b, 7'h0d, 7'h0e,
                                    7'h07};
   logic [6:0]         unused [5] = '{7'h02, 7'h09, 7'h0c, 7'h12, 7'h3f};
   csf_alu_t           alu_tab [10] = '{
      '{OP_ADD, 8'h00, 8'hff, 8'h01, 8'h00, 8'h07}, '{OP_ADD, 8'h00, 8'h7f, 8'h01, 8'h80, 8'h0a},
      '{OP_SUB, 8'h00, 8'h05, 8'h01, 8'h04, 8'h03}, '{OP_SUB, 8'h00, 8'h80, 8'h01, 8'h7f, 8'h09},
      '{OP_SUB, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00}, '{OP_AND, 8'h0b, 8'hf0, 8'h0f, 8'h00, 8'h0f},
      '{OP_OR,  8'h04, 8'h01, 8'h00, 8'h01, 8'h00}, '{OP_XOR, 8'h01, 8'h55, 8'h55, 8'h00, 8'h05},
      '{OP_RLC, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01}, '{OP_RRC, 8'h01, 8'h00, 8'h02, 8'h81, 8'h00}};

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
   $display("Error %0t: got %h want %h", $time, a, e); end end

   // =====================================================================
   // device under test
   csf_regs i_dut (
      .CLK          (clk),
      .NRST         (nrst),
      .CE           (ce),
      .INSTR_VALID  (vld),
      .INSTR        (instr),
      .TBL_WORD     (tbl),
      .PC_NOW       (pcn),
      .IRQ_ENTRY    (irq),
      .WDT_TIMEOUT  (wdt),
      .TIMER_INC    (tinc),
      .PC_JUMP      (jmp),
      .PC_TARGET    (tgt),
      .DUMMY_CYCLE  (dmy),
      .WORK_REG     (work),
      .STATUS_FLAGS (stat),
      .TBL_PTR      (tptr),
      .TIMER_COUNT  (tcnt),
      .TIMER_SETUP  (tset),
      .EXT_IRQ_EN   (ext_en),
      .TIMER_IRQ_EN (timer_en),
      .PORT_DIR     (dir),
      .PWM_DUTY     (duty)
   );

   // =====================================================================
   // tasks
   // verdict and end of run
   task summarize;
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // issue one instruction at a rising edge, return at its taking edge
   task ex(input csf_op_t op, input logic [6:0] a, input logic [7:0] i, input logic m);
      if (mid)
         @(posedge clk);
      mid = 1'b0;
      instr <= {op, 1'b0, a, i, m};
      vld <= 1'b1;
      @(posedge clk);
   endtask : ex

   // stop issuing and move to mid-cycle where outputs are settled
   task look;
      vld <= 1'b0;
      @(negedge clk);
      mid = 1'b1;
   endtask : look

   // write through the work register
   task wr(input logic [6:0] a, input logic [7:0] d);
      ex(OP_LOADI, 7'h00, d, 1'b0);
      ex(OP_STORE, a, 8'h00, 1'b0);
   endtask : wr

   // read into the work register and compare
   task rd(input logic [6:0] a, input logic [7:0] e);
      ex(OP_LOAD, a, 8'h00, 1'b0);
      look;
      `CHK(work, e)
   endtask : rd

   // one-cycle pulse on the event inputs {irq, wdt, tinc}
   task evt(input logic [2:0] e);
      if (mid)
         @(posedge clk);
      mid = 1'b0;
      {irq, wdt, tinc} <= e;
      vld <= 1'b0;
      @(posedge clk);
      {irq, wdt, tinc} <= 3'b000;
      @(negedge clk);
      mid = 1'b1;
   endtask : evt

   // =====================================================================
   // clock and run-time ceiling
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // cut a hang short
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         errors++;
         summarize;
      end
   end

   // =====================================================================
   // main sequence
   initial
   begin
      {nrst, vld, irq, wdt, tinc, mid} = 6'b000000;
      ce = 1'b1;
      instr = '0;
      tbl = 16'ha55a;
      pcn = 8'h3c;
      {errors, check_count, cyc} = {32'd0, 32'd0, 32'd0};
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      look;
      `CHK(stat, 8'h00)
      `CHK(dir, {4{8'hff}})
      rd(`CSF_A_PTR, 8'h80);
      wr(`CSF_A_PTR, 8'h45);
      rd(`CSF_A_PTR, 8'hc5);
      wr(`CSF_A_WIN, 8'h5a);
      rd(7'h45, 8'h5a);
      rd(`CSF_A_WIN, 8'h5a);
      wr(`CSF_A_PTR, 8'h00);
      wr(`CSF_A_WIN, 8'h33);
      rd(`CSF_A_WIN, 8'h00);
      foreach (unused[k])
      begin
         ex(OP_LOADI, 7'h00, 8'hff, 1'b0);
         rd(unused[k], 8'h00);
      end
      // direction, duty, timer and pointer registers
      foreach (regs[k])
         wr(regs[k], 8'h90 + 8'(k));
      look;
      `CHK({dir, duty, tcnt, tset, tptr}, 72'h90919293_9594_96_97_98)
      foreach (regs[k])
         rd(regs[k], 8'h90 + 8'(k));
      evt(3'b001);
      `CHK(tcnt, 8'h97)
      wr(`CSF_A_PC_LO, 8'h10);
      look;
      `CHK({jmp, dmy, tgt}, {2'b10, 8'h10})
      @(negedge clk);
      `CHK({jmp, dmy}, 2'b01)
      @(negedge clk);
      `CHK({jmp, dmy}, 2'b00)
      rd(`CSF_A_PC_LO, 8'h3c);
      ex(OP_TABRD, 7'h42, 8'h00, 1'b0);
      rd(7'h42, 8'h5a);
      wr(`CSF_A_TBL_HI, 8'h00);
      rd(`CSF_A_TBL_HI, 8'ha5);
      foreach (alu_tab[k])
      begin
         wr(`CSF_A_STAT, alu_tab[k].pre);
         wr(7'h41, alu_tab[k].m);
         ex(OP_LOADI, 7'h00, alu_tab[k].w, 1'b0);
         ex(alu_tab[k].op, 7'h41, 8'h00, 1'b0);
         look;
         `CHK(work, alu_tab[k].res)
         `CHK(stat, alu_tab[k].st)
      end
      // result sent to memory leaves the work register alone
      ex(OP_ADD, 7'h41, 8'h00, 1'b1);
      look;
      `CHK(work, 8'h81)
      rd(7'h41, 8'h83);
      evt(3'b010);
      `CHK(stat, 8'h20)
      ex(OP_HALT, 7'h00, 8'h00, 1'b0);
      look;
      `CHK(stat, 8'h10)
      wr(`CSF_A_STAT, 8'hff);
      look;
      `CHK(stat, 8'h1f)
      evt(3'b010);
      ex(OP_KICK, 7'h00, 8'h00, 1'b0);
      look;
      `CHK(stat, 8'h0f)
      wr(`CSF_A_IRQC, 8'h07);
      look;
      `CHK({ext_en, timer_en}, 2'b11)
      evt(3'b100);
      `CHK({ext_en, timer_en, stat}, {2'b00, 8'h0f})
      rd(`CSF_A_IRQC, 8'h06);
      ex(OP_IRQ_RET, 7'h00, 8'h00, 1'b0);
      look;
      `CHK({ext_en, timer_en}, 2'b11)
      wr(`CSF_A_IRQC, 8'h03);
      look;
      `CHK({ext_en, timer_en}, 2'b10)
      // clock enable low freezes the bank
      @(posedge clk);
      ce <= 1'b0;
      mid = 1'b0;
      ex(OP_LOADI, 7'h00, 8'h77, 1'b0);
      look;
      `CHK(work, 8'h03)
      @(posedge clk);
      ce <= 1'b1;
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
      look;
      `CHK({stat, dir}, {8'h00, {4{8'hff}}})
      summarize;
   end

endmodule : tb_csf_regs
